// ===== inc/phy_regs_defs.svh
// Offsets, field positions, reset values and codes of the management register block.
// Assumes nothing beyond a SystemVerilog compiler; holds definitions only.
`ifndef PHY_REGS_DEFS_SVH
`define PHY_REGS_DEFS_SVH

`define ADDR_AUX_SHADOW      16'hFFF8
`define ADDR_STATUS_SUMMARY  16'hFFF9
`define ADDR_SECOND_SHADOW   16'hFFFC

`define SEL_AUX_CTL          3'h0
`define SEL_POWER_CTL        3'h2
`define SEL_MISC_TEST        3'h4
`define SEL_MISC_CTL         3'h7

`define SEL2_SPARE_CTL2      5'h04
`define SEL2_AUTO_PWRDN      5'h0A

`define BIT_WRITE_EN         15
`define BIT_PKT_RX_MODE      11
`define BIT_FORCE_XOVER      9
`define BIT_DOWNGRADE_EN     4

`define RST_AUX_CTL          13'h0880
`define RST_POWER_CTL        13'h0000
`define RST_MISC_TEST        13'h0000
`define RST_MISC_UPPER       9'h002
`define RST_SPARE_CTL2       10'h000
`define RST_AUTO_PWRDN       10'h001

`define MIN_ATTEMPTS         4'h2

`define HREG_ADDR            8'h00
`define HREG_WDATA           8'h04
`define HREG_CTRL            8'h08
`define HREG_STATUS          8'h0C

`endif

// ===== inc/phy_regs_pkg.sv
// Types shared by both ends of the management link.
// Assumes the defines header is compiled alongside.
package phy_regs_pkg;
  typedef logic [15:0] mgmt_word_t;
  typedef logic [2:0]  common_mode_t;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01
  } station_state_t;
endpackage

// ===== inc/mgmt_if.sv
// Management link between the station controller and the register block.
// Assumes one shared clock; a request stands until acknowledged.
`timescale 1ns/100ps
interface mgmt_if;
  import phy_regs_pkg::*;
  logic       req;
  logic       we;
  mgmt_word_t addr;
  mgmt_word_t wdata;
  logic       ack;
  mgmt_word_t rdata;
  modport dev (input req, we, addr, wdata, output ack, rdata);
  modport sta (output req, we, addr, wdata, input ack, rdata);
endinterface

// ===== logic/phy_mgmt_regs.sv
// Shadow control and status summary registers of the 1000/100 section.
// Assumes negotiation event inputs are single-cycle pulses on i_clk.
//
// Our own choice: the AHB-Lite slave port.
`timescale 1ns/100ps
`include "phy_regs_defs.svh"
////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// RQ1: Bit 15 gates writes to bits 11:3.
// RQ2: Read selector always written, picks 18h read.
// RQ3: Low bits pick shadow; reserved codes unused.
// RQ4: Bit 11 chooses receive or transmit counting.
// RQ5: Bit 9 keeps crossover on without negotiation.
// RQ6: Downgrade advertisement after programmed failed attempts.
// RQ7: Downgrade off advertises programmed abilities exactly.
// RQ8: Bit 15 shows negotiation complete.
// RQ9: Bits 14:11 latch negotiation state entries.
// RQ10: Resolved mode field encodes agreed speed.
// RQ11: Mode reads zero until negotiation completes.
// RQ12: Forced mode shown unless crossover bit set.
// RQ13: Bit 7 latches parallel detection fault.
// RQ14: Bit 6 follows partner remote fault live.
// RQ15: Bit 5 latches new page received.
// RQ16: Bits 4,3 show partner abilities.
// RQ17: Bit 2 shows link pass state.
// RQ18: Bits 1:0 pause resolution, valid when complete.
// RQ19: Second address: selector 14:10, bit 15 gates.
// RQ20: Write selector first, next read returns shadow.
// RQ21: Codes 00100 spare control, 01010 power-down.
// RQ22: Controller preserves reserved bits by read-modify-write; the station only sends the whole word software wrote.
// RQ23: Retry field gives two to nine attempts.
// RQ24: Latched bits clear on read, event wins.
module phy_mgmt_regs (
  input  wire logic                        i_clk,
  input  wire logic                        i_rst,
  mgmt_if.dev                              mgmt,
  input  wire logic                        i_an_enabled,
  input  wire logic                        i_an_complete,
  input  wire logic [3:0]                  i_state_enter,
  input  wire phy_regs_pkg::common_mode_t  i_agreed_mode,
  input  wire phy_regs_pkg::common_mode_t  i_manual_mode,
  input  wire logic                        i_pd_fault,
  input  wire logic                        i_remote_fault,
  input  wire logic                        i_page_received,
  input  wire logic                        i_lp_an_able,
  input  wire logic                        i_lp_np_able,
  input  wire logic                        i_link_pass,
  input  wire logic                        i_pause_rx,
  input  wire logic                        i_pause_tx,
  input  wire logic                        i_attempt_failed,
  input  wire logic                        i_adv_1000,
  input  wire logic                        i_adv_100tx,
  output logic                             o_count_rx_packets,
  output logic                             o_auto_crossover_en,
  output logic                             o_adv_1000,
  output logic                             o_adv_100tx,
  output logic                             o_auto_pwrdn_en
);
  import phy_regs_pkg::*;

  logic [12:0]  aux_ctl;
  logic [12:0]  power_ctl;
  logic [12:0]  misc_test;
  logic [2:0]   read_sel;
  logic [8:0]   misc_upper;
  logic [4:0]   sel2;
  logic [9:0]   spare_ctl2;
  logic [9:0]   auto_pwrdn;
  logic [3:0]   state_lat;
  logic         pd_fault_lat;
  logic         page_lat;
  logic [3:0]   fail_count;
  logic [1:0]   downgrade_step;
  logic         take;
  logic         wr;
  logic         rd_status;
  mgmt_word_t   status_word;
  mgmt_word_t   next_rdata;
  common_mode_t shown_mode;

  //////////////////////////////////////////////////////////////////////////////
  // One request is taken per handshake; the ack cycle itself never takes one.
  assign take      = mgmt.req && !mgmt.ack;
  assign wr        = take && mgmt.we;
  assign rd_status = take && !mgmt.we && (mgmt.addr == `ADDR_STATUS_SUMMARY);

  //////////////////////////////////////////////////////////////////////////////
  // Aux shadow writes at FFF8.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      aux_ctl    <= `RST_AUX_CTL;
      power_ctl  <= `RST_POWER_CTL;
      misc_test  <= `RST_MISC_TEST;
      read_sel   <= 3'h0;
      misc_upper <= `RST_MISC_UPPER;
    end else if (wr && mgmt.addr == `ADDR_AUX_SHADOW) begin
      unique case (mgmt.wdata[2:0]) // RQ3
        `SEL_AUX_CTL:   aux_ctl   <= mgmt.wdata[15:3];
        `SEL_POWER_CTL: power_ctl <= mgmt.wdata[15:3];
        `SEL_MISC_TEST: misc_test <= mgmt.wdata[15:3];
        `SEL_MISC_CTL: begin
          read_sel <= mgmt.wdata[14:12]; // RQ2
          if (mgmt.wdata[`BIT_WRITE_EN]) begin
            misc_upper <= mgmt.wdata[11:3]; // RQ1
          end
        end
        default: ; // Reserved codes are ignored.
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Second shadow address FFFC.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel2       <= `SEL2_SPARE_CTL2;
      spare_ctl2 <= `RST_SPARE_CTL2;
      auto_pwrdn <= `RST_AUTO_PWRDN;
    end else if (wr && mgmt.addr == `ADDR_SECOND_SHADOW) begin
      sel2 <= mgmt.wdata[14:10]; // RQ19 RQ20
      if (mgmt.wdata[`BIT_WRITE_EN]) begin
        if (mgmt.wdata[14:10] == `SEL2_SPARE_CTL2) begin
          spare_ctl2 <= mgmt.wdata[9:0]; // RQ21
        end
        if (mgmt.wdata[14:10] == `SEL2_AUTO_PWRDN) begin
          auto_pwrdn <= mgmt.wdata[9:0]; // RQ21
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Misc control and auto power-down effects on the rest of the PHY.
  assign o_count_rx_packets  = misc_upper[`BIT_PKT_RX_MODE - 3]; // RQ4
  assign o_auto_crossover_en = i_an_enabled || misc_upper[`BIT_FORCE_XOVER - 3]; // RQ5
  assign o_auto_pwrdn_en     = auto_pwrdn[5];

  // Failed attempts are counted until the limit; the first downgrade drops gigabit,
  // the second drops 100TX. A good link restarts the sequence.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      fail_count     <= 4'h0;
      downgrade_step <= 2'h0;
    end else if (!misc_upper[`BIT_DOWNGRADE_EN - 3] || i_link_pass) begin
      fail_count     <= 4'h0;
      downgrade_step <= 2'h0; // RQ7
    end else if (i_attempt_failed) begin
      if (fail_count + 4'h1 >= {1'b0, spare_ctl2[4:2]} + `MIN_ATTEMPTS) begin // RQ23
        fail_count <= 4'h0;
        if (downgrade_step != 2'h2) begin
          downgrade_step <= downgrade_step + 2'h1; // RQ6
        end
      end else begin
        fail_count <= fail_count + 4'h1;
      end
    end
  end

  assign o_adv_1000  = i_adv_1000 && (downgrade_step == 2'h0); // RQ6 RQ7
  assign o_adv_100tx = i_adv_100tx && (downgrade_step != 2'h2); // RQ6 RQ7

  //////////////////////////////////////////////////////////////////////////////
  // Latched status; a new event in the reading cycle survives the clear.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state_lat    <= 4'h0;
      pd_fault_lat <= 1'b0;
      page_lat     <= 1'b0;
    end else begin
      state_lat    <= i_state_enter | (rd_status ? 4'h0 : state_lat); // RQ9 RQ24
      pd_fault_lat <= i_pd_fault || (pd_fault_lat && !rd_status); // RQ13 RQ24
      page_lat     <= i_page_received || (page_lat && !rd_status); // RQ15 RQ24
    end
  end

  always_comb begin
    if (i_an_enabled) begin
      shown_mode = i_an_complete ? i_agreed_mode : 3'h0; // RQ10 RQ11
    end else begin
      shown_mode = misc_upper[`BIT_FORCE_XOVER - 3] ? 3'h0 : i_manual_mode; // RQ12
    end
  end

  assign status_word = {i_an_complete, state_lat, shown_mode, // RQ8
                        pd_fault_lat, i_remote_fault, page_lat, // RQ14
                        i_lp_an_able, i_lp_np_able, i_link_pass, // RQ16 RQ17
                        i_pause_rx, i_pause_tx}; // RQ18

  //////////////////////////////////////////////////////////////////////////////
  // Read path; the write-enable bits always read back as zero.
  always_comb begin
    next_rdata = 16'h0000;
    unique case (mgmt.addr)
      `ADDR_AUX_SHADOW: begin
        unique case (read_sel) // RQ2
          `SEL_POWER_CTL: next_rdata = {power_ctl, `SEL_POWER_CTL};
          `SEL_MISC_TEST: next_rdata = {misc_test, `SEL_MISC_TEST};
          `SEL_MISC_CTL:  next_rdata = {1'b0, read_sel, misc_upper, `SEL_MISC_CTL};
          default:        next_rdata = {aux_ctl, `SEL_AUX_CTL};
        endcase
      end
      `ADDR_STATUS_SUMMARY: next_rdata = status_word;
      `ADDR_SECOND_SHADOW: begin
        if (sel2 == `SEL2_SPARE_CTL2) begin
          next_rdata = {1'b0, sel2, spare_ctl2}; // RQ20
        end else if (sel2 == `SEL2_AUTO_PWRDN) begin
          next_rdata = {1'b0, sel2, auto_pwrdn}; // RQ20
        end else begin
          next_rdata = {1'b0, sel2, 10'h000};
        end
      end
      default: next_rdata = 16'h0000;
    endcase
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      mgmt.ack   <= 1'b0;
      mgmt.rdata <= 16'h0000;
    end else begin
      mgmt.ack <= take;
      if (take && !mgmt.we) begin
        mgmt.rdata <= next_rdata;
      end
    end
  end
endmodule // phy_mgmt_regs

// ===== logic/mgmt_station.sv
// Station controller: AHB-Lite slave registers that issue management requests.
// Assumes a single AHB-Lite master and the register block on the same clock.
`timescale 1ns/100ps
`include "phy_regs_defs.svh"
module mgmt_station (
  input  wire logic        i_clk,
  input  wire logic        i_rst,
  input  wire logic        i_hsel,
  input  wire logic [31:0] i_haddr,
  input  wire logic [1:0]  i_htrans,
  input  wire logic        i_hwrite,
  input  wire logic [2:0]  i_hsize,
  input  wire logic [31:0] i_hwdata,
  input  wire logic        i_hready,
  output logic             o_hreadyout,
  output logic             o_hresp,
  output logic [31:0]      o_hrdata,
  output logic             o_pause_rx,
  output logic             o_pause_tx,
  mgmt_if.sta              mgmt
);
  import phy_regs_pkg::*;

  station_state_t state;
  logic [7:0]     ph_addr;
  logic           ph_write;
  mgmt_word_t     cmd_addr;
  mgmt_word_t     cmd_wdata;
  mgmt_word_t     last_rdata;
  logic           done;
  logic           refused;
  logic           start;
  logic           start_we;
  logic           code_bad;

  //////////////////////////////////////////////////////////////////////////////
  // Zero wait state slave; every answer is OKAY.
  assign o_hreadyout = 1'b1;
  assign o_hresp     = 1'b0;

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      ph_addr  <= 8'h00;
      ph_write <= 1'b0;
    end else if (i_hready) begin
      ph_write <= i_hsel && i_htrans[1] && i_hwrite;
      ph_addr  <= i_haddr[7:0];
    end
  end

  assign start    = ph_write && ph_addr == `HREG_CTRL && i_hwdata[0] && state == ST_IDLE;
  assign start_we = i_hwdata[1];

  // Reserved shadow codes are never sent to the device.
  always_comb begin
    code_bad = 1'b0;
    if (start_we && cmd_addr == `ADDR_AUX_SHADOW) begin
      code_bad = cmd_wdata[2:0] inside {3'h1, 3'h3, 3'h5, 3'h6}; // RQ3
    end
    if (start_we && cmd_addr == `ADDR_SECOND_SHADOW) begin
      code_bad = cmd_wdata[14:10] != `SEL2_SPARE_CTL2
              && cmd_wdata[14:10] != `SEL2_AUTO_PWRDN; // RQ21
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Software supplies whole words, so reserved bits carry what it read back.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      cmd_addr  <= 16'h0000;
      cmd_wdata <= 16'h0000;
    end else if (ph_write && state == ST_IDLE) begin
      if (ph_addr == `HREG_ADDR) begin
        cmd_addr <= i_hwdata[15:0];
      end
      if (ph_addr == `HREG_WDATA) begin
        cmd_wdata <= i_hwdata[15:0]; // RQ22
      end
    end
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      state      <= ST_IDLE;
      mgmt.req   <= 1'b0;
      mgmt.we    <= 1'b0;
      mgmt.addr  <= 16'h0000;
      mgmt.wdata <= 16'h0000;
      done       <= 1'b0;
      refused    <= 1'b0;
      last_rdata <= 16'h0000;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (start) begin
            done    <= 1'b0;
            refused <= code_bad;
            if (!code_bad) begin
              mgmt.req   <= 1'b1;
              mgmt.we    <= start_we;
              mgmt.addr  <= cmd_addr;
              mgmt.wdata <= cmd_wdata; // RQ20
              state      <= ST_WAIT;
            end
          end
        end
        ST_WAIT: begin
          if (mgmt.ack) begin
            mgmt.req <= 1'b0;
            done     <= 1'b1;
            state    <= ST_IDLE;
            if (!mgmt.we) begin
              last_rdata <= mgmt.rdata;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Pause results are only trusted when the completion bit came with them.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pause_rx <= 1'b0;
      o_pause_tx <= 1'b0;
    end else if (state == ST_WAIT && mgmt.ack && !mgmt.we
                 && mgmt.addr == `ADDR_STATUS_SUMMARY) begin
      o_pause_rx <= mgmt.rdata[15] && mgmt.rdata[1]; // RQ18
      o_pause_tx <= mgmt.rdata[15] && mgmt.rdata[0]; // RQ18
    end
  end

  always_comb begin
    unique case (ph_addr)
      `HREG_ADDR:   o_hrdata = {16'h0000, cmd_addr};
      `HREG_WDATA:  o_hrdata = {16'h0000, cmd_wdata};
      `HREG_STATUS: o_hrdata = {last_rdata, 13'h0000, refused, done, state == ST_WAIT};
      default:      o_hrdata = 32'h0000_0000;
    endcase
  end
endmodule // mgmt_station

// ===== tb/mgmt_link_props.sv
// Assertions on the management link between the station and the register block.
// Assumes one clock; instantiated beside the link interface in the bench top.
`timescale 1ns/100ps
`include "phy_regs_defs.svh"
module mgmt_link_props (
  input wire logic                     i_clk,
  input wire logic                     i_rst,
  input wire logic                     req,
  input wire logic                     we,
  input wire phy_regs_pkg::mgmt_word_t addr,
  input wire phy_regs_pkg::mgmt_word_t wdata,
  input wire logic                     ack,
  input wire phy_regs_pkg::mgmt_word_t rdata
);
  import phy_regs_pkg::*;
  logic [2:0] rsel;
  logic [2:0] mbits;
  logic [4:0] sel2;
  logic       wr;
  logic       rd;
  assign wr = req && !ack && we;
  assign rd = ack && !we;
  // Only fields visible on the link are modelled; device event inputs are not seen here.
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      rsel  <= 3'h0;
      mbits <= 3'h1;
    end else if (wr && addr == `ADDR_AUX_SHADOW && wdata[2:0] == `SEL_MISC_CTL) begin
      rsel <= wdata[14:12];
      if (wdata[15]) begin
        mbits <= {wdata[11], wdata[9], wdata[4]};
      end
    end
  end
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      sel2 <= `SEL2_SPARE_CTL2;
    end else if (wr && addr == `ADDR_SECOND_SHADOW) begin
      sel2 <= wdata[14:10];
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_rst);
  property p_answer; req && !ack |=> ack; endproperty
  property p_pulse; ack |=> !ack && !req; endproperty
  property p_hold; req && !ack |=> $stable(addr) && $stable(we) && $stable(wdata); endproperty
  property p_code;
    wr && addr == `ADDR_AUX_SHADOW |->
      wdata[2:0] inside {`SEL_AUX_CTL, `SEL_POWER_CTL, `SEL_MISC_TEST, `SEL_MISC_CTL};
  endproperty
  property p_code2;
    wr && addr == `ADDR_SECOND_SHADOW |-> wdata[14:10] inside {`SEL2_SPARE_CTL2, `SEL2_AUTO_PWRDN};
  endproperty
  property p_rsel; rd && addr == `ADDR_AUX_SHADOW |-> rdata[2:0] == rsel; endproperty
  property p_misc;
    rd && addr == `ADDR_AUX_SHADOW && rsel == `SEL_MISC_CTL |->
      {rdata[11], rdata[9], rdata[4]} == mbits && !rdata[15];
  endproperty
  property p_sel2; rd && addr == `ADDR_SECOND_SHADOW |-> rdata[14:10] == sel2; endproperty
  a_answer: assert property (p_answer)
    else $error("no answer one cycle after a request");
  a_pulse: assert property (p_pulse)
    else $error("answer longer than one cycle or request kept");
  a_hold: assert property (p_hold)
    else $error("request changed before its answer");
  a_code: assert property (p_code)
    else $error("reserved shadow code sent");
  a_code2: assert property (p_code2)
    else $error("unlisted second shadow code sent");
  a_rsel: assert property (p_rsel)
    else $error("shadow read does not follow the read selector");
  a_misc: assert property (p_misc)
    else $error("control bits updated without write enable");
  a_sel2: assert property (p_sel2)
    else $error("second shadow read shows the wrong selector");
  c_status: cover property (rd && addr == `ADDR_STATUS_SUMMARY);
  c_sel2: cover property (rd && addr == `ADDR_SECOND_SHADOW);
  c_gated: cover property (wr && addr == `ADDR_AUX_SHADOW && !wdata[15]);
endmodule // mgmt_link_props

// ===== tb/copper_phy_shadow_status_regs_tb_top.sv
// Bench joining the station and the register block over the management link.
// Assumes the bench is the only bus master and device events are single pulses.
`timescale 1ns/100ps
`include "phy_regs_defs.svh"
module copper_phy_shadow_status_regs_tb_top;
  import phy_regs_pkg::*;
  logic         clk, rst, hsel, hwrite, hrdy, prx, ptx, cnt_rx, xo, o1g, o100, apd;
  logic [1:0]   htrans;
  logic [31:0]  haddr, hwdata, hrdata, st;
  logic         an_en, an_done, pd, rf, pg, lp_an, lp_np, lnk, pz_rx, pz_tx, fail, a1g, a100;
  logic [3:0]   ent;
  common_mode_t agreed, manual;
  int           failures, samples_checked;
  mgmt_if mgmt_bus ();
  phy_mgmt_regs u_phy_mgmt_regs (.i_clk(clk), .i_rst(rst), .mgmt(mgmt_bus), .i_an_enabled(an_en),
    .i_an_complete(an_done), .i_state_enter(ent), .i_agreed_mode(agreed), .i_manual_mode(manual),
    .i_pd_fault(pd), .i_remote_fault(rf), .i_page_received(pg), .i_lp_an_able(lp_an),
    .i_lp_np_able(lp_np), .i_link_pass(lnk), .i_pause_rx(pz_rx), .i_pause_tx(pz_tx),
    .i_attempt_failed(fail), .i_adv_1000(a1g), .i_adv_100tx(a100), .o_count_rx_packets(cnt_rx),
    .o_auto_crossover_en(xo), .o_adv_1000(o1g), .o_adv_100tx(o100), .o_auto_pwrdn_en(apd));
  mgmt_station u_mgmt_station (.i_clk(clk), .i_rst(rst), .i_hsel(hsel), .i_haddr(haddr),
    .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2), .i_hwdata(hwdata), .i_hready(hrdy),
    .o_hreadyout(hrdy), .o_hresp(), .o_hrdata(hrdata), .o_pause_rx(prx), .o_pause_tx(ptx),
    .mgmt(mgmt_bus));
  mgmt_link_props u_mgmt_link_props (.i_clk(clk), .i_rst(rst), .req(mgmt_bus.req),
    .we(mgmt_bus.we), .addr(mgmt_bus.addr), .wdata(mgmt_bus.wdata), .ack(mgmt_bus.ack),
    .rdata(mgmt_bus.rdata));
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input string name, input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= wr;
    do @(posedge clk); while (hrdy !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge clk); while (hrdy !== 1'b1);
    st = hrdata;
  endtask
  // One full management transfer; st ends holding the final status word.
  task automatic mop(input logic wr, input mgmt_word_t a, input mgmt_word_t wd);
    ahb(1'b1, `HREG_ADDR, {16'h0, a});
    ahb(1'b1, `HREG_WDATA, {16'h0, wd});
    ahb(1'b1, `HREG_CTRL, {30'h0, wr, 1'b1});
    do ahb(1'b0, `HREG_STATUS, 32'h0); while (st[0] !== 1'b0 || st[2:1] === 2'b00);
  endtask
  // Ends on a falling edge so combinational outputs have settled before a check.
  task automatic fails(input int k);
    repeat (k) begin
      @(posedge clk);
      fail <= 1'b1;
      @(posedge clk);
      fail <= 1'b0;
    end
    @(negedge clk);
  endtask
  task automatic t_misc;
    logic [2:0]  c [3] = '{3'h2, 3'h4, 3'h0};
    logic [15:0] v [3] = '{16'h0002, 16'h0004, 16'h4400};
    mop(1'b0, `ADDR_AUX_SHADOW, 16'h0);
    chk("aux reset", st[31:16], 16'h4400);
    chk("reset outputs", {cnt_rx, xo, o1g, o100, apd}, 5'h06);
    mop(1'b1, `ADDR_AUX_SHADOW, 16'h7FFF);
    mop(1'b0, `ADDR_AUX_SHADOW, 16'h0);
    chk("misc gated", {st[27], st[25], st[20], st[18:16]}, 6'h0F);
    mop(1'b1, `ADDR_AUX_SHADOW, (st[31:16] | 16'hFA07) & 16'hFFEF);
    mop(1'b0, `ADDR_AUX_SHADOW, 16'h0);
    chk("misc set", {st[31], st[27], st[25], st[20]}, 4'h6);
    chk("rx count", cnt_rx, 1'b1);
    chk("crossover forced", xo, 1'b1);
    mop(1'b1, `ADDR_AUX_SHADOW, 16'hF017);
    chk("tx count", cnt_rx, 1'b0);
    chk("crossover off", xo, 1'b0);
    for (int i = 0; i < 3; i++) begin
      mop(1'b1, `ADDR_AUX_SHADOW, {1'b0, c[i], 12'h007});
      mop(1'b0, `ADDR_AUX_SHADOW, 16'h0);
      chk("shadow read", st[31:16], v[i]);
    end
    mop(1'b1, `ADDR_AUX_SHADOW, 16'h0003);
    chk("reserved code refused", st[2], 1'b1);
    $display("test misc done");
  endtask
  task automatic t_status;
    logic [2:0] m [5] = '{3'h7, 3'h6, 3'h5, 3'h4, 3'h3};
    @(posedge clk);
    an_en <= 1'b1;
    agreed <= 3'h7;
    {rf, lp_an, lp_np, lnk, pz_rx} <= 5'h1F;
    {ent, pd, pg} <= 6'h3F;
    @(posedge clk);
    {ent, pd, pg} <= 6'h00;
    mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
    chk("status latched", st[31:16], 16'h78FE);
    mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
    chk("status cleared", st[31:16], 16'h005E);
    chk("pause before complete", {prx, ptx}, 2'h0);
    @(posedge clk);
    pd <= 1'b1;
    @(posedge clk);
    pd <= 1'b0;
    mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
    chk("fault latched again", st[23], 1'b1);
    an_done <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      agreed <= m[i];
      mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
      chk("resolved mode", st[31:24], {5'h10, m[i]});
    end
    chk("pause after complete", {prx, ptx}, 2'h2);
    an_en <= 1'b0;
    manual <= 3'h5;
    lp_an <= 1'b0;
    mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
    chk("manual mode", st[26:24], 3'h5);
    chk("partner ability", st[20], 1'b0);
    mop(1'b1, `ADDR_AUX_SHADOW, 16'hF217);
    rf <= 1'b0;
    lnk <= 1'b0;
    mop(1'b0, `ADDR_STATUS_SUMMARY, 16'h0);
    chk("forced mode hidden", st[26:24], 3'h0);
    chk("live bits", st[22:18], 5'h02);
    chk("crossover kept", xo, 1'b1);
    mop(1'b1, `ADDR_AUX_SHADOW, 16'hF017);
    $display("test status done");
  endtask
  task automatic t_down;
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'h9000);
    fails(1);
    chk("one failure", {o1g, o100}, 2'h3);
    fails(1);
    chk("first downgrade", {o1g, o100}, 2'h1);
    fails(2);
    chk("second downgrade", {o1g, o100}, 2'h0);
    @(posedge clk);
    lnk <= 1'b1;
    @(posedge clk);
    lnk <= 1'b0;
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'h901C);
    chk("link restores", {o1g, o100}, 2'h3);
    fails(8);
    chk("eight failures", {o1g, o100}, 2'h3);
    fails(1);
    chk("nine failures", {o1g, o100}, 2'h1);
    mop(1'b1, `ADDR_AUX_SHADOW, 16'hF007);
    fails(9);
    chk("no downgrade", {o1g, o100}, 2'h3);
    @(posedge clk);
    a1g <= 1'b0;
    @(negedge clk);
    chk("programmed abilities", {o1g, o100}, 2'h1);
    $display("test downgrade done");
  endtask
  task automatic t_shadow;
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'hA820);
    chk("power-down on", apd, 1'b1);
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'h1000);
    mop(1'b0, `ADDR_SECOND_SHADOW, 16'h0);
    chk("spare read", st[30:16], 15'h101C);
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'h2BFF);
    mop(1'b0, `ADDR_SECOND_SHADOW, 16'h0);
    chk("power-down read", st[30:16], 15'h2820);
    chk("power-down kept", apd, 1'b1);
    mop(1'b1, `ADDR_SECOND_SHADOW, 16'h0C00);
    chk("bad selector refused", st[2], 1'b1);
    mop(1'b0, 16'h0000, 16'h0);
    chk("unmapped read", st[31:16], 16'h0000);
    ahb(1'b0, 8'h40, 32'h0);
    $display("test shadow done");
  endtask
  task automatic complete_run;
    $display("checks %0d failures %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////
  // The whole sequence needs several hundred cycles; this bound only catches a hang.
  initial begin
    repeat (30000) @(posedge clk);
    failures++;
    complete_run;
  end
  initial begin
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {an_en, an_done, pd, rf, pg, lp_an, lp_np, lnk, pz_rx, pz_tx, fail, ent} = '0;
    {a1g, a100} = 2'h3;
    agreed = 3'h0;
    manual = 3'h0;
    failures = 0;
    samples_checked = 0;
    rst = 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    t_misc;
    t_status;
    t_down;
    t_shadow;
    complete_run;
  end
endmodule // copper_phy_shadow_status_regs_tb_top
